// ===== common/pcgim_pkg.sv
// shared constants and types for the pll clock generator control block
package pcgim_pkg;
    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] OFF_CTRL   = 8'h00; // pll_control_reg
    localparam logic [7:0] OFF_BW     = 8'h04; // pll_bandwidth_control_reg
    localparam logic [7:0] OFF_CFG2   = 8'h08; // config_reg_two
    localparam logic [7:0] OFF_BRK    = 8'h0c; // break_flag_control_reg
    localparam logic [7:0] OFF_IRQ_ST = 8'h10; // interrupt status
    localparam logic [7:0] OFF_IRQ_EN = 8'h14; // interrupt enable
    localparam logic [7:0] OFF_IRQ_CL = 8'h18; // interrupt clear
    localparam logic [7:0] OFF_STAT   = 8'h1c; // live status

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int CTRL_IE    = 0; // pll_irq_enable
    localparam int CTRL_FLAG  = 1; // pll_irq_flag (read, write 0 clears)
    localparam int CTRL_BCS   = 2; // base_clock_select
    localparam int CTRL_PON   = 3; // pll_power_on
    localparam int BW_AUTO    = 0; // automatic bandwidth select
    localparam int BW_LOCK    = 1; // lock indicator (read only)
    localparam int CFG_OSCSTP = 0; // osc_run_in_stop
    localparam int BRK_BREAK_CLEAR_ENABLE   = 0; // break_clear_enable
    localparam int EV_LOCKCHG = 0; // lock change event
    localparam int EV_STOP    = 1; // stop entry event
    localparam int ST_STOP    = 0; // stop mode active
    localparam int ST_WAIT    = 1; // wait mode active
    localparam int ST_BCS     = 2; // pll clock engaged
    localparam int NEV        = 2;

    // ************************************************************
    // reset values and misc
    // ************************************************************
    localparam logic       RST_PON  = 1'b1;
    localparam logic [1:0] HTR_NSEQ = 2'h2;
    localparam logic [1:0] HTR_SEQ  = 2'h3;

    // clock enables toward the analog/gating cells
    typedef struct packed {
        logic osc_en;
        logic pll_en;
        logic bus_sel_vco;
        logic bus_clk_en;
        logic osc_clk_en;
    } pcgim_clk_ctl_t;
endpackage

// ===== core/pcgim_top.sv
// pll clock generator control with lock interrupt, low-power and break logic
// How it works
// [RULE1] with auto set, every lock edge raises a pll interrupt request
// [RULE2] request reaches the cpu only while pll_irq_enable is set
// [RULE3] flag sets on lock edges whether or not interrupts are enabled
// [RULE4] auto clear blocks pll interrupts and flag reads as zero
// [RULE5] software reads lock after an interrupt to learn its direction
// [RULE6] base_clock_select picks vco/2 as bus clock, even unlocked
// [RULE7] software should see lock before setting base_clock_select
// [RULE8] wait leaves oscillator, pll and clock selection unchanged
// [RULE9] clearing base_clock_select disengages pll, clearing power stops it
// [RULE10] powered but disengaged pll keeps running and may wake from wait
// [RULE11] stop with osc_run_in_stop clear kills osc, pll, outputs low
// [RULE12] stop with osc_run_in_stop set stops pll, oscillator keeps running
// [RULE13] break_clear_enable set lets break-state writes clear the flag
// [RULE14] a flag cleared during break stays cleared after break
// [RULE15] break_clear_enable clear: break accesses leave the flag untouched
// [RULE16] lock is synchronised before edge detection, one set per edge
//
// register map, one aligned word each
//   control      : irq enable, irq flag, base clock select, pll power
//   bandwidth    : automatic select, lock indicator (read only)
//   config two   : oscillator kept running in stop
//   break control: break clear enable
//   irq status   : lock change, stop entry (sticky, read only)
//   irq enable   : same layout as status
//   irq clear    : write one to clear a status bit
//   live status  : stop, wait, pll clock engaged
//
// hazards
//   the pll flag is written through the control word: a zero in its
//   bit clears it, so software must write a one there to keep it
//   a lock edge in the same cycle as a clear wins and keeps the flag
//
// Added by the designer: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
module pcgim_top (
    input  wire logic                     hclk,
    input  wire logic                     hresetn,
    input  wire logic                     hsel,
    input  wire logic [31:0]              haddr,
    input  wire logic [1:0]               htrans,
    input  wire logic                     hwrite,
    input  wire logic [2:0]               hsize,
    input  wire logic [31:0]              hwdata,
    input  wire logic                     hready,
    output logic      [31:0]              hrdata,
    output logic                          hreadyout,
    output logic                          hresp,
    input  wire logic                     pll_lock_in,
    input  wire logic                     break_state,
    input  wire logic                     stop_req,
    input  wire logic                     wait_req,
    input  wire logic                     wake_req,
    output pcgim_pkg::pcgim_clk_ctl_t     clk_ctl,
    output logic                          clockgen_irq_out,
    output logic                          pll_wake_out,
    output logic                          irq_out
);
    // ************************************************************
    // state
    // ************************************************************
    // software-visible control bits
    logic                      ie_q;
    logic                      flag_q;
    logic                      bcs_q;
    logic                      pon_q;
    logic                      auto_q;
    logic                      oscstp_q;
    logic                      break_clear_enable_q;
    // low-power mode tracking
    logic                      stop_q;
    logic                      wait_q;
    logic                      stop_p_q;
    // synchroniser stages
    logic                      lock_m_q;
    logic                      lock_s_q;
    logic                      lock_d_q;
    logic                      brk_m_q;
    logic                      brk_q;
    logic                      stop_m_q;
    logic                      stop_s_q;
    logic                      wait_m_q;
    logic                      wait_s_q;
    logic                      wake_m_q;
    logic                      wake_s_q;
    // sticky event status and its enables
    logic [pcgim_pkg::NEV-1:0] ev_st_q;
    logic [pcgim_pkg::NEV-1:0] ev_en_q;
    logic [pcgim_pkg::NEV-1:0] ev_set;
    logic [pcgim_pkg::NEV-1:0] ev_clr;
    // bus bookkeeping
    logic                      acc;
    logic                      ap_wr_q;
    logic                      ap_rd_q;
    logic [7:0]                ap_addr_q;
    logic [7:0]                rd_addr;
    logic [31:0]               rdata_d;
    // single-cycle strobes, plus the level gate brk_ok for break-time clears
    logic                      lock_edge;
    logic                      stop_edge;
    logic                      flag_clr;
    logic                      brk_ok;

    // ************************************************************
    // input synchronisers
    // ************************************************************
    // two flops per outside signal; only the second flop is read
    // the lock pin is asynchronous to hclk, so sampling it raw could
    // set the flag twice on one edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lock_m_q <= 1'b0;
            lock_s_q <= 1'b0;
            brk_m_q  <= 1'b0;
            brk_q    <= 1'b0;
            stop_m_q <= 1'b0;
            stop_s_q <= 1'b0;
            wait_m_q <= 1'b0;
            wait_s_q <= 1'b0;
            wake_m_q <= 1'b0;
            wake_s_q <= 1'b0;
        end else begin
            lock_m_q <= pll_lock_in; // [RULE16]
            lock_s_q <= lock_m_q;    // [RULE16]
            brk_m_q  <= break_state;
            brk_q    <= brk_m_q;
            stop_m_q <= stop_req;
            stop_s_q <= stop_m_q;
            wait_m_q <= wait_req;
            wait_s_q <= wait_m_q;
            wake_m_q <= wake_req;
            wake_s_q <= wake_m_q;
        end
    end

    // ************************************************************
    // bus address phase capture
    // ************************************************************
    assign acc = hsel && hready &&
                 (htrans == pcgim_pkg::HTR_NSEQ ||
                  htrans == pcgim_pkg::HTR_SEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_wr_q   <= 1'b0;
            ap_rd_q   <= 1'b0;
            ap_addr_q <= 8'h00;
        end else begin
            ap_wr_q   <= acc && hwrite;
            ap_rd_q   <= acc && !hwrite;
            ap_addr_q <= haddr[7:0];
        end
    end

    // ************************************************************
    // control registers
    // ************************************************************
    // writes land in the data phase; zero wait states
    // the flag bit of the control word is handled by the flag process
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ie_q     <= 1'b0;
            bcs_q    <= 1'b0;
            pon_q    <= pcgim_pkg::RST_PON;
            auto_q   <= 1'b0;
            oscstp_q <= 1'b0;
            break_clear_enable_q   <= 1'b0;
            ev_en_q  <= '0;
        end else if (ap_wr_q) begin
            unique case (ap_addr_q)
                pcgim_pkg::OFF_CTRL: begin
                    ie_q  <= hwdata[pcgim_pkg::CTRL_IE];
                    // selection accepted with or without lock
                    bcs_q <= hwdata[pcgim_pkg::CTRL_BCS]; // [RULE6] [RULE9]
                    pon_q <= hwdata[pcgim_pkg::CTRL_PON]; // [RULE9]
                end
                pcgim_pkg::OFF_BW:
                    auto_q <= hwdata[pcgim_pkg::BW_AUTO];
                pcgim_pkg::OFF_CFG2:
                    oscstp_q <= hwdata[pcgim_pkg::CFG_OSCSTP];
                pcgim_pkg::OFF_BRK:
                    break_clear_enable_q <= hwdata[pcgim_pkg::BRK_BREAK_CLEAR_ENABLE];
                pcgim_pkg::OFF_IRQ_EN:
                    ev_en_q <= hwdata[pcgim_pkg::NEV-1:0];
                default: ;
            endcase
        end
    end

    // ************************************************************
    // low-power mode tracking
    // ************************************************************
    // wait only recorded; it touches no clock control
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stop_q   <= 1'b0;
            wait_q   <= 1'b0;
            stop_p_q <= 1'b0;
        end else begin
            stop_q   <= stop_s_q;
            wait_q   <= wait_s_q && !wake_s_q; // [RULE8]
            stop_p_q <= stop_q;
        end
    end
    assign stop_edge = stop_q && !stop_p_q;

    // ************************************************************
    // lock edge and pll flag
    // ************************************************************
    // delayed copy of the synchronised lock; one edge gives one pulse,
    // in either direction, and only while automatic bandwidth is on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) lock_d_q <= 1'b0;
        else          lock_d_q <= lock_s_q;
    end
    assign lock_edge = auto_q && (lock_s_q ^ lock_d_q); // [RULE1] [RULE16]
    assign brk_ok    = !brk_q || break_clear_enable_q; // [RULE13] [RULE15]
    assign flag_clr  = ap_wr_q && ap_addr_q == pcgim_pkg::OFF_CTRL &&
                       !hwdata[pcgim_pkg::CTRL_FLAG] && brk_ok;

    // set wins over clear; flag held at zero while auto is off
    // a clear during break lands only when break clear is enabled, and
    // nothing sets the flag back on leaving break, so it stays cleared
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)       flag_q <= 1'b0;
        else if (!auto_q)   flag_q <= 1'b0;          // [RULE4]
        else if (lock_edge) flag_q <= 1'b1;          // [RULE3]
        else if (flag_clr)  flag_q <= 1'b0;          // [RULE14]
    end

    // ************************************************************
    // sticky interrupt status
    // ************************************************************
    assign ev_set = {stop_edge, lock_edge};
    assign ev_clr = (ap_wr_q && ap_addr_q == pcgim_pkg::OFF_IRQ_CL)
                    ? hwdata[pcgim_pkg::NEV-1:0] : '0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) ev_st_q <= '0;
        else          ev_st_q <= (ev_st_q & ~ev_clr) | ev_set;
    end

    // ************************************************************
    // outputs
    // ************************************************************
    // stop gating: pll always off; oscillator kept only if configured
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clk_ctl <= '0;
        end else begin
            clk_ctl.osc_en      <= !stop_q || oscstp_q;   // [RULE11] [RULE12]
            clk_ctl.pll_en      <= pon_q && !stop_q;     // [RULE9] [RULE12]
            clk_ctl.bus_sel_vco <= bcs_q;                 // [RULE6]
            clk_ctl.bus_clk_en  <= !stop_q;               // [RULE11]
            clk_ctl.osc_clk_en  <= !stop_q;               // [RULE11]
        end
    end

    // pll interrupt toward the cpu; held low in stop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            clockgen_irq_out <= 1'b0;
        end else begin
            // [RULE2] [RULE4] [RULE11]
            clockgen_irq_out <= flag_q && ie_q && auto_q && !stop_q;
        end
    end

    // pll may wake a waiting mcu, but never from stop where it is off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pll_wake_out <= 1'b0;
        end else begin
            pll_wake_out <= wait_q && pon_q && !stop_q &&
                            flag_q && ie_q; // [RULE10]
        end
    end

    // level interrupt from any enabled sticky status bit
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(ev_st_q & ev_en_q);
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    // read word is chosen from the address phase so that it can be
    // registered and stand on hrdata for the whole data phase
    assign rd_addr = haddr[7:0];

    always_comb begin
        rdata_d = 32'h0000_0000;
        unique case (rd_addr)
            pcgim_pkg::OFF_CTRL: begin
                rdata_d[pcgim_pkg::CTRL_IE]   = ie_q;
                rdata_d[pcgim_pkg::CTRL_FLAG] = flag_q && auto_q; // [RULE4]
                rdata_d[pcgim_pkg::CTRL_BCS]  = bcs_q;
                rdata_d[pcgim_pkg::CTRL_PON]  = pon_q;
            end
            pcgim_pkg::OFF_BW: begin
                rdata_d[pcgim_pkg::BW_AUTO] = auto_q;
                rdata_d[pcgim_pkg::BW_LOCK] = lock_s_q;
            end
            pcgim_pkg::OFF_CFG2:   rdata_d[pcgim_pkg::CFG_OSCSTP] = oscstp_q;
            pcgim_pkg::OFF_BRK:    rdata_d[pcgim_pkg::BRK_BREAK_CLEAR_ENABLE]   = break_clear_enable_q;
            pcgim_pkg::OFF_IRQ_ST: rdata_d[pcgim_pkg::NEV-1:0]    = ev_st_q;
            pcgim_pkg::OFF_IRQ_EN: rdata_d[pcgim_pkg::NEV-1:0]    = ev_en_q;
            pcgim_pkg::OFF_STAT: begin
                rdata_d[pcgim_pkg::ST_STOP] = stop_q;
                rdata_d[pcgim_pkg::ST_WAIT] = wait_q;
                rdata_d[pcgim_pkg::ST_BCS]  = bcs_q;
            end
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    // reads return in the data phase cycle, registered at address phase
    // limitation: a read right behind a write to the same word sees the
    // value from before that write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else begin
            hrdata <= (acc && !hwrite) ? rdata_d : 32'h0000_0000;
        end
    end

    // no wait states and no error response: every access is accepted
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end
    // data phase read strobe kept for a later stall hook
    logic unused_rd;
    assign unused_rd = ap_rd_q;
endmodule

// ===== verif/pcgim_assertions.sv
// port-level property checker for the pll clock generator control block
`timescale 1ns/1ps
module pcgim_assertions (
    input wire logic                      hclk,
    input wire logic                      hresetn,
    input wire logic                      hsel,
    input wire logic                      hreadyout,
    input wire logic                      hresp,
    input wire logic                      pll_lock_in,
    input wire logic                      break_state,
    input wire logic                      stop_req,
    input wire logic                      wait_req,
    input wire pcgim_pkg::pcgim_clk_ctl_t clk_ctl,
    input wire logic                      clockgen_irq_out,
    input wire logic                      pll_wake_out,
    input wire logic                      irq_out
);
    logic [3:0] quiet_q;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ************************************************************
    // cycles since the last input that may start an interrupt
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            quiet_q <= 4'h0;
        else if (hsel || $changed(pll_lock_in) || $changed(stop_req)
                 || $changed(wait_req) || $changed(break_state))
            quiet_q <= 4'h0;
        else if (quiet_q != 4'hf)
            quiet_q <= quiet_q + 4'h1;
    end
    // ************************************************************
    // properties
    // ************************************************************
    property p_bus_ready; hreadyout; endproperty
    a_bus_ready: assert property (p_bus_ready) else $error("wait state seen");
    property p_bus_okay; !hresp; endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("error response");
    property p_stop_pll_off; stop_req [*5] |-> !clk_ctl.pll_en; endproperty
    a_stop_pll_off: assert property (p_stop_pll_off)
        else $error("pll still enabled in stop");
    property p_stop_irq_low; stop_req [*5] |-> !clockgen_irq_out; endproperty
    a_stop_irq_low: assert property (p_stop_irq_low)
        else $error("clock generator interrupt high in stop");
    property p_wait_stable;
        (wait_req && !stop_req && !hsel) [*6] |-> $stable(clk_ctl);
    endproperty
    a_wait_stable: assert property (p_wait_stable)
        else $error("clock controls moved in wait");
    property p_wake_powered; pll_wake_out |-> clk_ctl.pll_en; endproperty
    a_wake_powered: assert property (p_wake_powered)
        else $error("wake request from an unpowered pll");
    property p_irq_cause; $rose(clockgen_irq_out) |-> quiet_q < 4'ha;
    endproperty
    a_irq_cause: assert property (p_irq_cause)
        else $error("pll interrupt rose with no cause");
    property p_sys_irq_cause; $rose(irq_out) |-> quiet_q < 4'ha; endproperty
    a_sys_irq_cause: assert property (p_sys_irq_cause)
        else $error("interrupt line rose with no cause");
    c_irq: cover property ($rose(clockgen_irq_out));
    c_wake: cover property (pll_wake_out);
    c_stop: cover property (stop_req [*5]);
endmodule
bind pcgim_top pcgim_assertions chk_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .hreadyout(hreadyout),
    .hresp(hresp), .pll_lock_in(pll_lock_in), .break_state(break_state),
    .stop_req(stop_req), .wait_req(wait_req), .clk_ctl(clk_ctl),
    .clockgen_irq_out(clockgen_irq_out), .pll_wake_out(pll_wake_out),
    .irq_out(irq_out)
);

// ===== verif/pll_clock_gen_interrupt_modes_bench.sv
// self-checking bench for the pll clock generator control block
`timescale 1ns/1ps
module pll_clock_gen_interrupt_modes_bench;
    logic                      hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic                      pll_lock_in, break_state, stop_req, wait_req;
    logic                      gen_irq, wake_out, irq_out;
    logic [1:0]                htrans;
    logic [31:0]               haddr, hwdata, hrdata, rd;
    pcgim_pkg::pcgim_clk_ctl_t clk_ctl, ctl_snap;
    int                        failures, n_checks;

    pcgim_top dut_u (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pll_lock_in(pll_lock_in), .break_state(break_state),
        .stop_req(stop_req), .wait_req(wait_req), .wake_req(1'b0),
        .clk_ctl(clk_ctl), .clockgen_irq_out(gen_irq),
        .pll_wake_out(wake_out), .irq_out(irq_out)
    );

    // 100 MHz clock
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic results();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // bounded wait for hready sampled high
    task automatic hold();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
            results();
        end
    endtask
    // one single ahb transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= pcgim_pkg::HTR_NSEQ;
        hold();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        hold();
        rd = hrdata;
    endtask
    task automatic lock(input logic v);
        pll_lock_in <= v;
        tick(8);
    endtask

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_auto_off();
        chk(32'(clk_ctl), 32'h1b);
        bus(1'b0, pcgim_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h8);
        bus(1'b1, pcgim_pkg::OFF_CTRL, 32'h9);
        lock(1'b1);
        chk(32'(gen_irq), 32'h0);
        bus(1'b0, pcgim_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h9);
        lock(1'b0);
        bus(1'b1, 8'h40, 32'hffffffff);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_flag();
        bus(1'b1, pcgim_pkg::OFF_BW, 32'h1);
        bus(1'b1, pcgim_pkg::OFF_CTRL, 32'h8);
        lock(1'b1);
        chk(32'(gen_irq), 32'h0);
        bus(1'b0, pcgim_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'ha);
        bus(1'b1, pcgim_pkg::OFF_CTRL, 32'hb);
        tick(2);
        chk(32'(gen_irq), 32'h1);
        bus(1'b1, pcgim_pkg::OFF_CTRL, 32'h9);
        tick(8);
        chk(32'(gen_irq), 32'h0);
        lock(1'b0);
        chk(32'(gen_irq), 32'h1);
        bus(1'b0, pcgim_pkg::OFF_BW, 32'h0);
        chk(rd, 32'h1);
        bus(1'b1, pcgim_pkg::OFF_IRQ_EN, 32'h1);
        tick(2);
        chk(32'(irq_out), 32'h1);
        bus(1'b1, pcgim_pkg::OFF_IRQ_CL, 32'h1);
        bus(1'b1, pcgim_pkg::OFF_CTRL, 32'h8);
        tick(2);
        chk(32'(irq_out), 32'h0);
    endtask
    task automatic t_wait();
        bus(1'b1, pcgim_pkg::OFF_CTRL, 32'hc);
        tick(3);
        chk(32'(clk_ctl.bus_sel_vco), 32'h1);
        bus(1'b1, pcgim_pkg::OFF_CTRL, 32'h0);
        tick(3);
        chk(32'(clk_ctl), 32'h13);
        bus(1'b1, pcgim_pkg::OFF_CTRL, 32'h9);
        lock(1'b1);
        bus(1'b0, pcgim_pkg::OFF_BW, 32'h0);
        chk(rd, 32'h3);
        ctl_snap = clk_ctl;
        wait_req <= 1'b1;
        tick(8);
        chk(32'(wake_out), 32'h1);
        chk(32'(clk_ctl), 32'(ctl_snap));
        wait_req <= 1'b0;
        lock(1'b0);
    endtask
    task automatic t_stop();
        bus(1'b1, pcgim_pkg::OFF_IRQ_EN, 32'h0);
        bus(1'b1, pcgim_pkg::OFF_CFG2, 32'h0);
        stop_req <= 1'b1;
        tick(8);
        chk(32'(clk_ctl), 32'h0);
        chk(32'(gen_irq), 32'h0);
        chk(32'(irq_out), 32'h0);
        stop_req <= 1'b0;
        tick(8);
        bus(1'b0, pcgim_pkg::OFF_IRQ_ST, 32'h0);
        chk(rd & 32'h2, 32'h2);
        bus(1'b1, pcgim_pkg::OFF_IRQ_EN, 32'h2);
        tick(2);
        chk(32'(irq_out), 32'h1);
        bus(1'b1, pcgim_pkg::OFF_CFG2, 32'h1);
        stop_req <= 1'b1;
        tick(8);
        chk(32'(clk_ctl.osc_en), 32'h1);
        chk(32'(clk_ctl.pll_en), 32'h0);
        stop_req <= 1'b0;
        tick(8);
        bus(1'b1, pcgim_pkg::OFF_IRQ_CL, 32'h3);
        bus(1'b1, pcgim_pkg::OFF_CTRL, 32'h8);
        tick(2);
        chk(32'(irq_out), 32'h0);
    endtask
    task automatic t_break();
        lock(1'b1);
        break_state <= 1'b1;
        tick(3);
        bus(1'b1, pcgim_pkg::OFF_BRK, 32'h0);
        bus(1'b1, pcgim_pkg::OFF_CTRL, 32'h8);
        bus(1'b0, pcgim_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'ha);
        bus(1'b1, pcgim_pkg::OFF_BRK, 32'h1);
        bus(1'b1, pcgim_pkg::OFF_CTRL, 32'h8);
        bus(1'b0, pcgim_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h8);
        break_state <= 1'b0;
        tick(3);
        bus(1'b0, pcgim_pkg::OFF_CTRL, 32'h0);
        chk(rd, 32'h8);
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        failures = 0;
        n_checks = 0;
        hresetn = 1'b0;
        {hsel, hwrite, pll_lock_in, break_state, stop_req, wait_req} = 6'h0;
        {htrans, haddr, hwdata} = 66'h0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        tick(2);
        t_auto_off();
        t_flag();
        t_wait();
        t_stop();
        t_break();
        results();
    end
endmodule
